// File: tb/sere_monitor.sv
// concurrent checks on the two-wire link between both ends
`timescale 1ns/1ps
module sere_monitor import sere_pkg::*; #(
  parameter logic [2:0] SEL = 3'h0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic scl,
  input wire logic sda,
  input wire logic m_sda_out,
  input wire logic m_sda_oe,
  input wire logic s_sda_out,
  input wire logic s_sda_oe
);
  logic scl_reg;
  logic sda_reg;
  logic first_reg;
  logic rd_reg;
  logic [3:0] cnt_reg;
  logic [7:0] shift_reg;
  // line events seen at the bench clock
  wire rise = scl && !scl_reg;
  wire start = scl && scl_reg && sda_reg && !sda;
  wire stop = scl && scl_reg && !sda_reg && sda;
  wire ninth = rise && (cnt_reg == 4'h8);
  wire match = (shift_reg[7:1] == {SERE_DEV_CODE, SEL});
  // previous line levels for edge detection
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      scl_reg <= 1'b1;
      sda_reg <= 1'b1;
    end else begin
      scl_reg <= scl;
      sda_reg <= sda;
    end
  end
  // bit slot tracking; a nack drops read mode so the stop clock is not misread
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= 4'h0;
      first_reg <= 1'b0;
      rd_reg <= 1'b0;
      shift_reg <= 8'h00;
    end else if (start) begin
      cnt_reg <= 4'h0;
      first_reg <= 1'b1;
      rd_reg <= 1'b0;
    end else if (ninth) begin
      cnt_reg <= 4'h0;
      first_reg <= 1'b0;
      rd_reg <= first_reg ? (shift_reg[0] && match) : (rd_reg && !sda);
    end else if (rise) begin
      cnt_reg <= cnt_reg + 4'h1;
      shift_reg <= {shift_reg[6:0], sda};
    end
  end
  default clocking mon_cb @(posedge clk); endclocking
  default disable iff (rst);
  addr_ack_a: assert property (ninth && first_reg && match |-> !sda)
    else $error("own address not acknowledged");
  addr_ignore_a: assert property (ninth && first_reg && !match |-> sda)
    else $error("foreign address acknowledged");
  ack_release_a: assert property (ninth && !first_reg && rd_reg |-> !s_sda_oe)
    else $error("device drove the master acknowledge slot");
  read_owner_a: assert property (rise && !ninth && rd_reg && !first_reg |-> !m_sda_oe)
    else $error("master drove a read data bit");
  high_stable_a: assert property (scl && scl_reg |-> $stable(s_sda_oe))
    else $error("device changed data while clock high");
  stop_free_a: assert property (stop |-> !s_sda_oe)
    else $error("device still driving at stop");
  start_master_a: assert property (start |-> m_sda_oe)
    else $error("start not made by the master");
  open_drain_a: assert property (!m_sda_out && !s_sda_out)
    else $error("data line driven high");
  cover property (ninth && first_reg && match && shift_reg[0]);
  cover property (ninth && rd_reg && !first_reg && !sda);
  cover property (ninth && first_reg && !match);
endmodule : sere_monitor

// File: tb/sere_tb.sv
// self-checking bench: master end reads the eeprom end over the link
`timescale 1ns/1ps
module sere_tb import sere_pkg::*;;
  localparam logic [2:0] SEL = 3'h5;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wr_en = 1'b0;
  logic [SERE_ADDR_W-1:0] wr_addr = 15'h0000;
  logic [7:0] wr_data = 8'h00;
  logic req = 1'b0;
  logic req_random = 1'b0;
  logic [6:0] req_dev = 7'h00;
  logic [SERE_ADDR_W-1:0] req_addr = 15'h0000;
  logic [7:0] req_len = 8'h00;
  logic rd_valid;
  logic done;
  logic nack_err;
  logic idle;
  logic busy;
  logic [7:0] rd_data;
  int failures = 0;
  int total_checks = 0;
  // 200 MHz bench clock
  always #2.5 clk = ~clk;
  sere_if sere_if_inst();
  sere_dev sere_dev_inst(.clk(clk), .rst(rst), .bus(sere_if_inst.dev),
    .select_pin_bit0(SEL[0]), .select_pin_bit1(SEL[1]), .select_pin_bit2(SEL[2]),
    .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data), .busy(busy));
  sere_mst sere_mst_inst(.clk(clk), .rst(rst), .bus(sere_if_inst.mst), .req(req),
    .req_random(req_random), .req_dev(req_dev), .req_addr(req_addr), .req_len(req_len),
    .rd_valid(rd_valid), .rd_data(rd_data), .done(done), .nack_err(nack_err), .idle(idle));
  sere_monitor #(.SEL(SEL)) sere_monitor_inst(.clk(clk), .rst(rst), .scl(sere_if_inst.scl),
    .sda(sere_if_inst.sda), .m_sda_out(sere_if_inst.m_sda_out),
    .m_sda_oe(sere_if_inst.m_sda_oe), .s_sda_out(sere_if_inst.s_sda_out),
    .s_sda_oe(sere_if_inst.s_sda_oe));
  task automatic finish_test;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : finish_test
  task automatic check_byte(string name, logic [7:0] exp, logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", name, exp, got);
    end
  endtask : check_byte
  task automatic check_bit(string name, logic exp, logic got);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s: expected %b seen %b", name, exp, got);
    end
  endtask : check_bit
  // array preload; the edge first keeps back-to-back calls from double driving
  task automatic preload(logic [14:0] addr, logic [7:0] data);
    @(posedge clk);
    wr_addr <= addr;
    wr_data <= data;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : preload
  // one transaction; outputs sampled at the falling edge where they are settled
  task automatic run_read(logic rnd, logic [6:0] dev, logic [14:0] addr, logic [7:0] len,
      logic [15:0] exp, logic [7:0] exp_cnt, logic exp_nack);
    int n;
    int k;
    n = 0;
    k = 0;
    while (idle !== 1'b1 && k < 100) begin
      @(negedge clk);
      k++;
    end
    if (idle !== 1'b1) begin
      failures++;
      finish_test();
    end
    @(posedge clk);
    req_random <= rnd;
    req_dev <= dev;
    req_addr <= addr;
    req_len <= len;
    req <= 1'b1;
    @(posedge clk);
    req <= 1'b0;
    k = 0;
    do begin
      @(negedge clk);
      k++;
      if (rd_valid === 1'b1) begin
        check_byte("read data", (n == 0) ? exp[15:8] : exp[7:0], rd_data);
        check_bit("device busy", 1'b1, busy);
        n++;
      end
    end while (done !== 1'b1 && k < 80000);
    if (done !== 1'b1) begin
      failures++;
      finish_test();
    end
    check_byte("byte count", exp_cnt, 8'(n));
    check_bit("address refused", exp_nack, nack_err);
    check_bit("device busy", 1'b0, busy);
  endtask : run_read
  // distinct bytes at the top and bottom of the array show the wrap
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    preload(15'h7fff, 8'h5a);
    preload(15'h0000, 8'hc3);
    preload(15'h0001, 8'h96);
    run_read(1'b1, {SERE_DEV_CODE, SEL}, 15'h7fff, 8'h02, 16'h5ac3, 8'h02, 1'b0);
    run_read(1'b0, {SERE_DEV_CODE, SEL}, 15'h1234, 8'h01, 16'h9600, 8'h01, 1'b0);
    run_read(1'b0, {SERE_DEV_CODE, 3'h2}, 15'h0000, 8'h01, 16'h0000, 8'h00, 1'b1);
    finish_test();
  end
endmodule : sere_tb

// File: verilog/sere_dev.sv
// eeprom slave end: address match, address counter and read path
`timescale 1ns/1ps
// Summary of operation
// - read starts as write, direction bit one
// - counter holds last accessed address plus one
// - counter wraps from top to zero
// - ack read address, then shift counter byte
// - single read: master nacks then stops
// - random read: dummy write of address bytes
// - repeated start, read address, device returns byte
// - master acks to continue sequential read
// - each master ack yields next consecutive byte
// - nack then stop ends read; release data
// - read increments all address bits, wraps
// - match 1010 and three select inputs
// - two address bytes load the counter
// - receiver pulls data low on ninth pulse; the device leaves write data bytes unacked and waits for stop
// - no ack: release line, idle until stop
module sere_dev import sere_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  sere_if.dev bus,
  input wire logic select_pin_bit0,
  input wire logic select_pin_bit1,
  input wire logic select_pin_bit2,
  input wire logic wr_en,
  input wire logic [SERE_ADDR_W-1:0] wr_addr,
  input wire logic [7:0] wr_data,
  output logic busy
);
  typedef enum logic [2:0] {
    SERE_IDLE = 3'b000,
    SERE_DEVADR = 3'b001,
    SERE_ADRHI = 3'b010,
    SERE_ADRLO = 3'b011,
    SERE_WRDATA = 3'b100,
    SERE_RDDATA = 3'b101,
    SERE_WAITSTOP = 3'b110
  } sere_state_e;

  logic [7:0] mem [0:SERE_DEPTH-1];
  sere_state_e state_reg;
  logic [3:0] bit_reg;
  logic [7:0] sh_reg;
  logic [SERE_ADDR_W-1:0] cnt_reg;
  logic [6:0] adr_hi_reg;
  logic drv_reg;
  logic ack_reg;
  logic busy_reg;
  logic scl_q;
  logic scl_rise;
  logic scl_fall;
  logic sda_q;
  logic sda_rise;
  logic sda_fall;
  logic [2:0] sel_meta_reg;
  logic [2:0] sel_reg;

  sere_sync u_scl (.clk(clk), .rst(rst), .din(bus.scl), .q(scl_q), .rise(scl_rise),
    .fall(scl_fall));
  sere_sync u_sda (.clk(clk), .rst(rst), .din(bus.sda), .q(sda_q), .rise(sda_rise),
    .fall(sda_fall));

  // conditions: data moving while the clock is high
  wire start_det = sda_fall && scl_q;
  wire stop_det = sda_rise && scl_q;
  wire [7:0] rx_byte = {sh_reg[6:0], sda_q};
  wire [6:0] my_addr = {SERE_DEV_CODE, sel_reg};
  // the whole byte sits in sh_reg once the eighth rise has shifted it in
  wire addr_hit = (sh_reg[7:1] == my_addr);
  wire is_read = sh_reg[0];
  wire ninth = (bit_reg == SERE_BIT_LAST);
  wire [SERE_ADDR_W-1:0] cnt_inc = cnt_reg + 15'h0001;
  wire [7:0] rd_byte = mem[cnt_reg];

  // the engine reacts to clock edges only while a frame is in progress
  function automatic logic sere_engaged(sere_state_e s);
    return (s != SERE_IDLE) && (s != SERE_WAITSTOP);
  endfunction : sere_engaged
  wire engaged = sere_engaged(state_reg);

  // select pins are board straps from outside the clock domain; first flop feeds only the second
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sel_meta_reg <= 3'h0;
      sel_reg <= 3'h0;
    end else begin
      sel_meta_reg <= {select_pin_bit2, select_pin_bit1, select_pin_bit0};
      sel_reg <= sel_meta_reg;
    end
  end

  // memory preload; the write path here is only a simple direct port
  initial begin
    for (int i = 0; i < SERE_DEPTH; i++) begin
      mem[i] = SERE_MEM_INIT;
    end
  end
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // bit engine: sample on scl rise, change data on scl fall
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= SERE_IDLE;
      bit_reg <= 4'h0;
      sh_reg <= 8'h00;
      cnt_reg <= 15'h0000;
      adr_hi_reg <= 7'h00;
      drv_reg <= 1'b0;
      ack_reg <= 1'b0;
    end else if (start_det) begin
      // a repeated start aborts whatever was in flight
      state_reg <= SERE_DEVADR;
      bit_reg <= SERE_BIT_ARM; // the fall that ends the start is not a bit
      drv_reg <= 1'b0;
      ack_reg <= 1'b0;
    end else if (stop_det) begin
      state_reg <= SERE_IDLE;
      drv_reg <= 1'b0;
      ack_reg <= 1'b0;
    end else if (scl_rise && engaged) begin
      // while sending, a rise must not disturb the outgoing shift register
      if (!ninth && state_reg != SERE_RDDATA) begin
        sh_reg <= rx_byte;
      end else if (ninth && state_reg == SERE_RDDATA) begin
        if (sda_q) begin
          state_reg <= SERE_WAITSTOP;
        end
      end
    end else if (scl_fall && engaged) begin
      if (bit_reg == 4'h7) begin
        bit_reg <= SERE_BIT_LAST;
        drv_reg <= 1'b0;
        case (state_reg)
          SERE_DEVADR: begin
            ack_reg <= addr_hit;
            if (!addr_hit) begin
              state_reg <= SERE_WAITSTOP;
            end
          end
          SERE_ADRHI: begin
            ack_reg <= 1'b1;
            adr_hi_reg <= sh_reg[6:0];
          end
          SERE_ADRLO: begin
            ack_reg <= 1'b1;
            cnt_reg <= {adr_hi_reg, sh_reg};
          end
          SERE_WRDATA: begin
            ack_reg <= 1'b0; // data bytes belong to the write path
            state_reg <= SERE_WAITSTOP;
          end
          SERE_RDDATA: begin
            ack_reg <= 1'b0; // master acks, not us
          end
          default: begin
            state_reg <= SERE_IDLE;
          end
        endcase
      end else if (ninth) begin
        bit_reg <= 4'h0;
        ack_reg <= 1'b0;
        drv_reg <= 1'b0;
        case (state_reg)
          SERE_DEVADR: begin
            if (is_read) begin
              state_reg <= SERE_RDDATA;
              sh_reg <= rd_byte;
              cnt_reg <= cnt_inc;
              drv_reg <= 1'b1;
            end else begin
              state_reg <= SERE_ADRHI;
            end
          end
          SERE_ADRHI: state_reg <= SERE_ADRLO;
          SERE_ADRLO: state_reg <= SERE_WRDATA;
          SERE_RDDATA: begin
            // master acked: next consecutive byte
            sh_reg <= rd_byte;
            cnt_reg <= cnt_inc;
            drv_reg <= 1'b1;
          end
          default: state_reg <= SERE_IDLE;
        endcase
      end else begin
        bit_reg <= bit_reg + 4'h1;
        if (state_reg == SERE_RDDATA) begin
          sh_reg <= {sh_reg[6:0], 1'b0};
        end
      end
    end
  end

  // open-drain drive: only ever pulls low, registered
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bus.s_sda_oe <= 1'b0;
      busy_reg <= 1'b0;
    end else begin
      bus.s_sda_oe <= ack_reg || (drv_reg && !sh_reg[7]);
      busy_reg <= (state_reg != SERE_IDLE);
    end
  end
  assign bus.s_sda_out = 1'b0;
  assign busy = busy_reg;
endmodule : sere_dev

// File: verilog/sere_if.sv
// two-wire link between the eeprom read engine and its bus master
`timescale 1ns/1ps
interface sere_if;
  logic scl;
  logic m_sda_out;
  logic m_sda_oe;
  logic s_sda_out;
  logic s_sda_oe;
  // open-drain wired and: any enabled driver pulls low
  wire sda = !((m_sda_oe && !m_sda_out) || (s_sda_oe && !s_sda_out));
  modport dev (input scl, input sda, output s_sda_out, output s_sda_oe);
  modport mst (output scl, input sda, output m_sda_out, output m_sda_oe);
endinterface : sere_if

// File: verilog/sere_mst.sv
// bus master end: makes the link clock and runs read transactions
`timescale 1ns/1ps
module sere_mst import sere_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  sere_if.mst bus,
  input wire logic req,
  input wire logic req_random,
  input wire logic [6:0] req_dev,
  input wire logic [SERE_ADDR_W-1:0] req_addr,
  input wire logic [7:0] req_len,
  output logic rd_valid,
  output logic [7:0] rd_data,
  output logic done,
  output logic nack_err,
  output logic idle
);
  typedef enum logic [2:0] {
    SEREM_IDLE = 3'b000,
    SEREM_START = 3'b001,
    SEREM_BYTE = 3'b010,
    SEREM_STOP = 3'b011,
    SEREM_FIN = 3'b100
  } sere_mstate_e;
  typedef enum logic [2:0] {
    SEREM_P_WADR = 3'b000,
    SEREM_P_AHI = 3'b001,
    SEREM_P_ALO = 3'b010,
    SEREM_P_RADR = 3'b011,
    SEREM_P_DATA = 3'b100
  } sere_mphase_e;

  sere_mstate_e st_reg;
  sere_mphase_e ph_reg;
  logic [9:0] tick_reg;
  logic [1:0] q_reg; // quarter: 0 low-set, 1 rise, 2 high, 3 fall
  logic [3:0] bit_reg;
  logic [7:0] tx_reg;
  logic [7:0] rx_reg;
  logic [7:0] left_reg;
  logic scl_reg;
  logic sda_reg;
  logic rd_valid_reg;
  logic done_reg;
  logic nack_reg;
  logic idle_reg;
  logic sda_q;

  sere_sync u_sda (.clk(clk), .rst(rst), .din(bus.sda), .q(sda_q), .rise(), .fall());

  wire tick = (tick_reg == SERE_QTR_CNT);
  wire [7:0] radr = {req_dev, 1'b1};
  wire [7:0] wadr = {req_dev, 1'b0};
  wire last_byte = (left_reg == 8'h01);

  // the master divides its clock to make scl; one tick per quarter of the link period
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tick_reg <= 10'h000;
    end else begin
      tick_reg <= tick ? 10'h000 : tick_reg + 10'h001;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg <= SEREM_IDLE;
      ph_reg <= SEREM_P_WADR;
      q_reg <= 2'h0;
      bit_reg <= 4'h0;
      tx_reg <= 8'h00;
      rx_reg <= 8'h00;
      left_reg <= 8'h00;
      scl_reg <= 1'b1;
      sda_reg <= 1'b1;
      rd_valid_reg <= 1'b0;
      done_reg <= 1'b0;
      nack_reg <= 1'b0;
      idle_reg <= 1'b1;
    end else begin
      rd_valid_reg <= 1'b0;
      done_reg <= 1'b0;
      if (st_reg == SEREM_IDLE) begin
        if (req) begin
          st_reg <= SEREM_START;
          idle_reg <= 1'b0;
          q_reg <= 2'h0;
          left_reg <= (req_len == 8'h00) ? 8'h01 : req_len;
          ph_reg <= req_random ? SEREM_P_WADR : SEREM_P_RADR;
          tx_reg <= req_random ? wadr : radr;
          nack_reg <= 1'b0;
        end
      end else if (tick) begin
        q_reg <= q_reg + 2'h1;
        case (st_reg)
          SEREM_START: begin
            // q0 sda high scl high, q1 sda low (start), q2 scl low
            if (q_reg == 2'h0) begin
              sda_reg <= 1'b1;
              scl_reg <= 1'b1;
            end else if (q_reg == 2'h1) begin
              sda_reg <= 1'b0;
            end else if (q_reg == 2'h2) begin
              scl_reg <= 1'b0;
            end else begin
              st_reg <= SEREM_BYTE;
              bit_reg <= 4'h0;
              q_reg <= 2'h0;
            end
          end
          SEREM_BYTE: begin
            if (q_reg == 2'h0) begin
              if (bit_reg == SERE_BIT_LAST) begin
                // ack slot: release to read, or ack a data byte
                sda_reg <= !(ph_reg == SEREM_P_DATA && !last_byte);
              end else begin
                sda_reg <= (ph_reg == SEREM_P_DATA) ? 1'b1 : tx_reg[7];
              end
            end else if (q_reg == 2'h1) begin
              scl_reg <= 1'b1;
            end else if (q_reg == 2'h2) begin
              if (bit_reg != SERE_BIT_LAST) begin
                rx_reg <= {rx_reg[6:0], sda_q};
                tx_reg <= {tx_reg[6:0], 1'b0};
              end
            end else begin
              scl_reg <= 1'b0;
              if (bit_reg != SERE_BIT_LAST) begin
                bit_reg <= bit_reg + 4'h1;
              end else begin
                bit_reg <= 4'h0;
                case (ph_reg)
                  SEREM_P_DATA: begin
                    rd_valid_reg <= 1'b1;
                    left_reg <= left_reg - 8'h01;
                    if (last_byte) begin
                      st_reg <= SEREM_STOP;
                    end
                  end
                  default: begin
                    if (sda_q) begin
                      nack_reg <= 1'b1;
                      st_reg <= SEREM_STOP;
                    end else if (ph_reg == SEREM_P_WADR) begin
                      ph_reg <= SEREM_P_AHI;
                      tx_reg <= {1'b0, req_addr[14:8]};
                    end else if (ph_reg == SEREM_P_AHI) begin
                      ph_reg <= SEREM_P_ALO;
                      tx_reg <= req_addr[7:0];
                    end else if (ph_reg == SEREM_P_ALO) begin
                      ph_reg <= SEREM_P_RADR; // no data byte
                      tx_reg <= radr;
                      st_reg <= SEREM_START;
                    end else begin
                      ph_reg <= SEREM_P_DATA;
                    end
                  end
                endcase
              end
            end
          end
          SEREM_STOP: begin
            // sda low, scl high, then sda high while scl high
            if (q_reg == 2'h0) begin
              sda_reg <= 1'b0;
            end else if (q_reg == 2'h1) begin
              scl_reg <= 1'b1;
            end else if (q_reg == 2'h2) begin
              sda_reg <= 1'b1;
            end else begin
              st_reg <= SEREM_FIN;
            end
          end
          default: begin
            done_reg <= 1'b1;
            idle_reg <= 1'b1;
            st_reg <= SEREM_IDLE;
          end
        endcase
      end
    end
  end

  assign bus.scl = scl_reg;
  assign bus.m_sda_out = 1'b0;
  assign bus.m_sda_oe = !sda_reg;
  assign rd_data = rx_reg;
  assign rd_valid = rd_valid_reg;
  assign done = done_reg;
  assign nack_err = nack_reg;
  // registered twin of the idle state, so the port comes from a flop
  assign idle = idle_reg;
endmodule : sere_mst

// File: verilog/sere_pkg.sv
// shared constants for the serial eeprom read engine
package sere_pkg;
  localparam int SERE_ADDR_W = 15;
  localparam int SERE_DEPTH = 32768;
  localparam logic [3:0] SERE_DEV_CODE = 4'ha;
  localparam logic [7:0] SERE_MEM_INIT = 8'h00;
  localparam int SERE_CLK_MHZ = 200;
  localparam int SERE_SCL_PERIOD_NS = 2500;
  // quarter link period in cycles of the master's own clock; four quarters make one period
  localparam int SERE_SCL_QTR_CYC = SERE_SCL_PERIOD_NS * SERE_CLK_MHZ / 4000;
  localparam logic [9:0] SERE_QTR_CNT = 10'(SERE_SCL_QTR_CYC - 1);
  localparam logic [3:0] SERE_BIT_LAST = 4'h8;
  // bit count parked after a start; the next fall wraps it to bit zero
  localparam logic [3:0] SERE_BIT_ARM = 4'hf;
endpackage : sere_pkg

// File: verilog/sere_sync.sv
// two-stage synchroniser with edge and level outputs
`timescale 1ns/1ps
module sere_sync (
  input wire logic clk,
  input wire logic rst,
  input wire logic din,
  output logic q,
  output logic rise,
  output logic fall
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  // s1 feeds only s2; edges come from later stages
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_reg <= 1'b1;
      s2_reg <= 1'b1;
      s3_reg <= 1'b1;
    end else begin
      s1_reg <= din;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end
  assign q = s2_reg;
  assign rise = s2_reg && !s3_reg;
  assign fall = !s2_reg && s3_reg;
endmodule : sere_sync
